/* File: acc_consts.svh */
// Operation
// [RL1] Three amplified channels, gains 5/10/20/40.
// [RL2] Sync to PWM event or ADC clock/8.
// [RL3] Start with sync low: 13 ADC cycles.
// [RL4] Start with sync high: 14 ADC cycles.
// [RL5] Pick sync source first; amplify each event.
// [RL6] Refuse other channel starts during amplified conversion.
// [RL7] Abort and restart when amplifier output changes.
// [RL8] PWM trigger rate below ADC clock/4.
// [RL9] Auto trigger starts at next amplifier event.
// [RL10] No free running with amplified auto trigger.
// [RL11] Decode reference select with pin bits.
// [RL12] Reference change deferred until conversion done.
// [RL13] Alignment bit re-views result immediately.
// [RL14] Decode five-bit channel select field.
// [RL15] Channel change deferred until conversion done.
// [RL16] Enable clear takes effect after conversion.
// [RL17] Start bit launches; hardware clears; zero ignored.
// [RL18] First conversion also initialises converter.
// [RL19] Auto trigger bit selects auto trigger mode.
// [RL20] Done flag set on completion, write-one clears.
// [RL21] Result split over high and low registers.
// [RL22] Low read locks results until high read.
// [RL23] Prescaler divides system clock 2 to 128.
// [RL24] Auto trigger on rising source flag edge.
// [RL25] Start bit stays set across abort restart.
`ifndef ACC_CONSTS_SVH
`define ACC_CONSTS_SVH
`define ACC_OFF_MUX      12'h000
`define ACC_OFF_CTLA     12'h004
`define ACC_OFF_CTLB     12'h008
`define ACC_OFF_RESL     12'h00C
`define ACC_OFF_RESH     12'h010
`define ACC_OFF_AMP0     12'h014
`define ACC_OFF_AMP1     12'h018
`define ACC_OFF_AMP2     12'h01C
`define ACC_RST_MUX      8'h00
`define ACC_RST_CTLA     8'h00
`define ACC_RST_CTLB     8'h00
`define ACC_RST_AMP      8'h00
`define ACC_BIT_EN       7
`define ACC_BIT_START    6
`define ACC_BIT_AUTO     5
`define ACC_BIT_DONE     4
`define ACC_BIT_ALIGN    5
`define ACC_BIT_AMPEN    7
`define ACC_CYC_NORMAL   5'h0D
`define ACC_CYC_SYNC     5'h0E
`define ACC_CYC_INIT     5'h19
`define ACC_SYNC_DIV     3'h7
`define ACC_CH_AMP0      5'h0E
`define ACC_CH_AMP2      5'h10
`define ACC_TS_FREE      4'h0
`endif

/* File: acc_pkg.sv */
package acc_pkg;
    typedef enum logic [2:0] {
        ACC_IDLE = 3'b001,
        ACC_WAIT = 3'b010,
        ACC_CONV = 3'b100
    } acc_state_t;
    typedef struct packed {
        logic [7:0] ref_pos;
        logic [7:0] ctla;
        logic [7:0] ctlb;
        logic [7:0] amp0;
        logic [7:0] amp1;
        logic [7:0] amp2;
    } acc_regs_t;
    typedef struct packed {
        acc_regs_t  r;
        logic [1:0] ref_act;
        logic [4:0] ch_act;
        acc_state_t st;
        logic [6:0] pre_cnt;
        logic       adc_tick;
        logic [2:0] div8;
        logic [4:0] cyc;
        logic       init_done;
        logic       armed;
        logic       trig_d;
        logic       free_pend;
        logic [9:0] result;
        logic       locked;
        logic       awv;
        logic       wv;
        logic [11:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic       bvalid;
        logic [1:0] bresp;
        logic       rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } acc_state_s_t;
    typedef struct packed {
        logic [1:0] reference_select;
        logic       ref_pin_connect;
        logic       current_source_enable;
        logic [4:0] channel_select;
        logic [1:0] amp_gain;
        logic       sample;
        logic       converter_enable;
        logic       init_cycle;
    } acc_analog_t;
endpackage

/* File: acc_top.sv */
// Design decisions made here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`include "acc_consts.svh"
module acc_top (
    // Clock and reset.
    input  wire logic                 mclk_i,
    input  wire logic                 rstn_i,
    // AXI4-Lite slave.
    input  wire logic [11:0]          s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    input  wire logic [11:0]          s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    // Triggers and converter.
    input  wire logic [13:0]          trig_flags_i,
    input  wire logic [2:0]           pwm_sync_i,
    input  wire logic                 amp_out_change_i,
    input  wire logic [9:0]           conv_data_i,
    output acc_pkg::acc_analog_t      analog_o,
    output logic                      conv_done_pulse_o
);
    acc_pkg::acc_state_s_t s_reg;
    acc_pkg::acc_state_s_t s_next;

    // Divide-by factor of the prescaler, minus one.
    function automatic logic [6:0] pre_limit(input logic [2:0] code);
        logic [7:0] d;
        d = (code == 3'h0) ? 8'h02 : (8'h01 << code);
        return 7'(d - 8'h01);
    endfunction

    // True when the channel is an amplified one.
    function automatic logic is_amp(input logic [4:0] ch);
        return (ch >= `ACC_CH_AMP0) && (ch <= `ACC_CH_AMP2); // RL14
    endfunction

    function automatic logic [7:0] amp_reg(input acc_pkg::acc_regs_t r, input logic [4:0] ch);
        logic [7:0] v;
        v = r.amp0;
        if (ch == 5'h0F) begin
            v = r.amp1;
        end else if (ch == `ACC_CH_AMP2) begin
            v = r.amp2;
        end
        return v;
    endfunction

    logic [7:0] res_hi;
    logic [7:0] res_lo;
    logic [7:0] ampr;
    logic       amp_evt;
    logic       trig_now;
    logic       wr_go;
    logic       rd_go;

    always_comb begin
        // RL13: alignment is a read-time view, so it changes at once.
        if (s_reg.r.ref_pos[`ACC_BIT_ALIGN]) begin
            res_hi = s_reg.result[9:2]; // RL13 RL21
            res_lo = {s_reg.result[1:0], 6'h00};
        end else begin
            res_hi = {6'h00, s_reg.result[9:8]}; // RL21
            res_lo = s_reg.result[7:0];
        end
        ampr = amp_reg(s_reg.r, s_reg.ch_act);
        // RL2 RL5: amplifier event is the PWM sync or the ADC clock divided by eight.
        if (ampr[1:0] == 2'h0) begin
            amp_evt = s_reg.adc_tick && (s_reg.div8 == `ACC_SYNC_DIV); // RL2
        end else begin
            amp_evt = pwm_sync_i[ampr[1:0] - 2'h1]; // RL2 RL8
        end
        amp_evt = amp_evt && ampr[`ACC_BIT_AMPEN]; // RL5
        trig_now = 1'b0;
        if (s_reg.r.ctlb[3:0] != `ACC_TS_FREE && s_reg.r.ctlb[3:0] <= 4'hD) begin
            trig_now = trig_flags_i[s_reg.r.ctlb[3:0] - 4'h1];
        end
    end

    assign wr_go = s_reg.awv && s_reg.wv && !s_reg.bvalid;
    assign rd_go = s_axi_arvalid && !s_reg.rvalid;
    assign s_axi_awready = !s_reg.awv && !s_reg.bvalid;
    assign s_axi_wready = !s_reg.wv && !s_reg.bvalid;
    assign s_axi_arready = !s_reg.rvalid;
    assign s_axi_bvalid = s_reg.bvalid;
    assign s_axi_bresp = s_reg.bresp;
    assign s_axi_rvalid = s_reg.rvalid;
    assign s_axi_rdata = s_reg.rdata;
    assign s_axi_rresp = s_reg.rresp;

    always_comb begin
        logic       done;
        logic       start_req;
        logic       amp_ch;
        logic [7:0] wb;
        logic [7:0] rb;
        logic       hit;
        done = 1'b0;
        start_req = 1'b0;
        amp_ch = is_amp(s_reg.ch_act);
        wb = s_reg.wdata[7:0];
        rb = 8'h00;
        hit = 1'b1;
        s_next = s_reg;

        // ---------------------------------------------------------------
        // Clock generation
        // ---------------------------------------------------------------
        s_next.adc_tick = 1'b0;
        if (s_reg.pre_cnt >= pre_limit(s_reg.r.ctla[2:0])) begin
            s_next.pre_cnt = 7'h00; // RL23
            s_next.adc_tick = 1'b1;
            s_next.div8 = 3'(s_reg.div8 + 3'h1);
        end else begin
            s_next.pre_cnt = 7'(s_reg.pre_cnt + 7'h01);
        end

        // ---------------------------------------------------------------
        // Triggering
        // ---------------------------------------------------------------
        s_next.trig_d = trig_now;
        if (trig_now && !s_reg.trig_d) begin
            s_next.armed = 1'b1; // RL24
        end

        // ---------------------------------------------------------------
        // Conversion sequencer
        // ---------------------------------------------------------------
        unique case (s_reg.st)
            acc_pkg::ACC_IDLE: begin
                s_next.ref_act = s_reg.r.ref_pos[7:6];
                s_next.ch_act = s_reg.r.ref_pos[4:0];
                if (!s_reg.r.ctla[`ACC_BIT_EN]) begin
                    s_next.init_done = 1'b0;
                    s_next.r.ctla[`ACC_BIT_START] = 1'b0;
                end else if (s_reg.r.ctla[`ACC_BIT_START] && s_reg.adc_tick) begin
                    start_req = 1'b1; // RL17
                end else if (s_reg.r.ctla[`ACC_BIT_AUTO] && s_reg.armed && s_reg.adc_tick) begin
                    start_req = 1'b1; // RL19 RL24
                    s_next.armed = 1'b0;
                end else if (s_reg.r.ctla[`ACC_BIT_AUTO] && s_reg.free_pend && s_reg.adc_tick
                             && !is_amp(s_reg.r.ref_pos[4:0])) begin
                    start_req = 1'b1; // RL10
                end
                if (start_req) begin
                    s_next.cyc = s_reg.init_done ? `ACC_CYC_NORMAL : `ACC_CYC_INIT; // RL18
                    s_next.free_pend = 1'b0;
                    if (is_amp(s_reg.r.ref_pos[4:0])) begin
                        s_next.st = acc_pkg::ACC_WAIT; // RL9
                        // RL3 RL4: sync high costs one extra ADC cycle.
                        if (s_reg.div8[2] && s_reg.init_done) begin
                            s_next.cyc = `ACC_CYC_SYNC; // RL4
                        end else if (s_reg.init_done) begin
                            s_next.cyc = `ACC_CYC_NORMAL; // RL3
                        end
                        // Only a trigger-started amplified conversion waits for the amplifier event.
                        if (s_reg.r.ctla[`ACC_BIT_START]) begin
                            s_next.st = acc_pkg::ACC_CONV;
                        end
                    end else begin
                        s_next.st = acc_pkg::ACC_CONV;
                    end
                end
            end
            acc_pkg::ACC_WAIT: begin
                if (amp_evt) begin
                    s_next.st = acc_pkg::ACC_CONV; // RL9
                end
            end
            acc_pkg::ACC_CONV: begin
                if (amp_ch && amp_out_change_i && s_reg.cyc >= 5'h0B) begin
                    s_next.cyc = `ACC_CYC_NORMAL; // RL7 RL25
                end else if (s_reg.adc_tick) begin
                    if (s_reg.cyc == 5'h01) begin
                        done = 1'b1;
                    end
                    s_next.cyc = 5'(s_reg.cyc - 5'h01);
                end
            end
            default: begin
                s_next.st = acc_pkg::ACC_IDLE;
            end
        endcase
        if (done) begin
            s_next.st = acc_pkg::ACC_IDLE; // RL6
            s_next.init_done = 1'b1;
            s_next.r.ctla[`ACC_BIT_START] = 1'b0; // RL17 RL25
            s_next.free_pend = s_reg.r.ctla[`ACC_BIT_AUTO] && s_reg.r.ctlb[3:0] == `ACC_TS_FREE; // RL24
            if (!s_reg.locked) begin
                s_next.result = conv_data_i;
            end
        end

        // ---------------------------------------------------------------
        // Register writes
        // ---------------------------------------------------------------
        if (s_axi_awready && s_axi_awvalid) begin
            s_next.awv = 1'b1;
            s_next.awaddr = s_axi_awaddr;
        end
        if (s_axi_wready && s_axi_wvalid) begin
            s_next.wv = 1'b1;
            s_next.wdata = s_axi_wdata;
            s_next.wstrb = s_axi_wstrb;
        end
        if (s_reg.bvalid && s_axi_bready) begin
            s_next.bvalid = 1'b0;
        end
        if (wr_go) begin
            s_next.awv = 1'b0;
            s_next.wv = 1'b0;
            s_next.bvalid = 1'b1;
            s_next.bresp = 2'h0;
            if (s_reg.wstrb[0]) begin
                unique case (s_reg.awaddr)
                    `ACC_OFF_MUX: s_next.r.ref_pos = wb; // RL12 RL15
                    `ACC_OFF_CTLA: begin
                        s_next.r.ctla[7] = wb[7]; // RL16
                        s_next.r.ctla[5] = wb[5]; // RL19
                        s_next.r.ctla[3:0] = wb[3:0];
                        if (wb[`ACC_BIT_START]) begin
                            s_next.r.ctla[`ACC_BIT_START] = 1'b1; // RL17
                        end
                        if (wb[`ACC_BIT_DONE] && !done) begin
                            s_next.r.ctla[`ACC_BIT_DONE] = 1'b0; // RL20
                        end
                    end
                    `ACC_OFF_CTLB: s_next.r.ctlb = {wb[7:5], 1'b0, wb[3:0]};
                    `ACC_OFF_AMP0: s_next.r.amp0 = wb; // RL1 RL5
                    `ACC_OFF_AMP1: s_next.r.amp1 = wb;
                    `ACC_OFF_AMP2: s_next.r.amp2 = wb;
                    `ACC_OFF_RESL, `ACC_OFF_RESH: begin
                    end
                    default: s_next.bresp = 2'h2;
                endcase
            end
        end
        if (done) begin
            s_next.r.ctla[`ACC_BIT_DONE] = 1'b1; // RL20
        end

        // ---------------------------------------------------------------
        // Register reads
        // ---------------------------------------------------------------
        if (s_reg.rvalid && s_axi_rready) begin
            s_next.rvalid = 1'b0;
        end
        if (rd_go) begin
            unique case (s_axi_araddr)
                `ACC_OFF_MUX: rb = s_reg.r.ref_pos;
                `ACC_OFF_CTLA: rb = s_reg.r.ctla;
                `ACC_OFF_CTLB: rb = s_reg.r.ctlb;
                `ACC_OFF_RESL: begin
                    rb = res_lo;
                    s_next.locked = 1'b1; // RL22
                end
                `ACC_OFF_RESH: begin
                    rb = res_hi;
                    s_next.locked = 1'b0; // RL22
                end
                `ACC_OFF_AMP0: rb = s_reg.r.amp0;
                `ACC_OFF_AMP1: rb = s_reg.r.amp1;
                `ACC_OFF_AMP2: rb = s_reg.r.amp2;
                default: hit = 1'b0;
            endcase
            s_next.rvalid = 1'b1;
            s_next.rdata = {24'h000000, rb};
            s_next.rresp = hit ? 2'h0 : 2'h2;
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_reg <= '0;
            s_reg.st <= acc_pkg::ACC_IDLE;
        end else begin
            s_reg <= s_next;
        end
    end

    // RL11: pin bits come from control B, codes pass to the analog side.
    always_comb begin
        analog_o.reference_select = s_reg.ref_act; // RL11 RL12
        analog_o.ref_pin_connect = s_reg.r.ctlb[5];
        analog_o.current_source_enable = s_reg.r.ctlb[6];
        analog_o.channel_select = s_reg.ch_act; // RL14 RL15
        analog_o.amp_gain = ampr[5:4]; // RL1
        analog_o.sample = s_reg.st == acc_pkg::ACC_CONV && s_reg.cyc >= 5'h0B;
        analog_o.converter_enable = s_reg.r.ctla[`ACC_BIT_EN] || s_reg.st != acc_pkg::ACC_IDLE; // RL16
        analog_o.init_cycle = !s_reg.init_done && s_reg.st != acc_pkg::ACC_IDLE; // RL18
    end
    assign conv_done_pulse_o = s_reg.r.ctla[`ACC_BIT_DONE];
endmodule

/* File: acc_chk.sv */
`timescale 1ns/1ps
`include "acc_consts.svh"
module acc_chk (
    // Clock and reset.
    input wire logic                 mclk_i,
    input wire logic                 rstn_i,
    // Bus.
    input wire logic                 s_axi_wvalid,
    input wire logic [1:0]           s_axi_rresp,
    input wire logic                 s_axi_rvalid,
    // Converter side.
    input wire logic                 amp_out_change_i,
    input wire acc_pkg::acc_analog_t analog_o,
    input wire logic                 conv_done_pulse_o
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rstn_i);
    // The second sample cycle is used so that the latch on leaving idle is not mistaken for a change.
    property p_chan_stable;
        analog_o.sample && $past(analog_o.sample) |-> $stable(analog_o.channel_select);
    endproperty
    property p_ref_stable;
        analog_o.sample && $past(analog_o.sample) |-> $stable(analog_o.reference_select);
    endproperty
    property p_done_holds;
        conv_done_pulse_o && !s_axi_wvalid && !$past(s_axi_wvalid) |=> conv_done_pulse_o;
    endproperty
    property p_abort;
        analog_o.sample && amp_out_change_i && analog_o.channel_select >= `ACC_CH_AMP0
            && analog_o.channel_select <= `ACC_CH_AMP2 |=> analog_o.sample;
    endproperty
    property p_sample_en;
        analog_o.sample |-> analog_o.converter_enable;
    endproperty
    property p_done_en;
        $rose(conv_done_pulse_o) |-> $past(analog_o.converter_enable);
    endproperty
    property p_init_end;
        $fell(analog_o.init_cycle) |-> conv_done_pulse_o;
    endproperty
    property p_rresp_legal;
        s_axi_rvalid |-> (s_axi_rresp == 2'h0 || s_axi_rresp == 2'h2);
    endproperty
    a_chan_stable: assert property (p_chan_stable) else $error("channel moved during sampling");
    a_ref_stable: assert property (p_ref_stable) else $error("reference moved during sampling");
    a_done_holds: assert property (p_done_holds) else $error("done flag dropped unasked");
    a_abort: assert property (p_abort) else $error("conversion finished despite abort");
    a_sample_en: assert property (p_sample_en) else $error("sampling while disabled");
    a_done_en: assert property (p_done_en) else $error("completion while disabled");
    a_init_end: assert property (p_init_end) else $error("init ended without completion");
    a_rresp_legal: assert property (p_rresp_legal) else $error("bad read response");
    c_done: cover property ($rose(conv_done_pulse_o));
    c_abort: cover property (analog_o.sample && amp_out_change_i);
    c_init: cover property (analog_o.init_cycle);
endmodule

bind acc_top acc_chk i_chk (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .s_axi_wvalid(s_axi_wvalid), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .amp_out_change_i(amp_out_change_i), .analog_o(analog_o),
    .conv_done_pulse_o(conv_done_pulse_o)
);

/* File: acc_far_model.sv */
`timescale 1ns/1ps
module acc_far_model (
    input  wire logic                 mclk_i,
    input  wire logic                 rstn_i,
    input  wire acc_pkg::acc_analog_t analog_o,
    input  wire logic [9:0]           data_val,
    input  wire logic                 abort_req,
    input  wire logic                 trig_req,
    output logic [9:0]                conv_data_i,
    output logic                      amp_out_change_i,
    output logic [2:0]                pwm_sync_i,
    output logic [13:0]               trig_flags_i
);
    logic [6:0] pwm_cnt;
    logic       abort_used;
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pwm_cnt <= 7'h00;
            amp_out_change_i <= 1'h0;
            abort_used <= 1'h0;
        end else begin
            pwm_cnt <= pwm_cnt + 7'h01;
            amp_out_change_i <= abort_req && !abort_used && analog_o.sample;
            abort_used <= abort_req && (abort_used || amp_out_change_i);
        end
    end
    // One event every 128 clocks stays well under a quarter of the ADC clock.
    assign pwm_sync_i = {3{pwm_cnt == 7'h00}};
    assign trig_flags_i = {13'h0000, trig_req};
    // A disabled converter does not hold its last word on the lines.
    assign conv_data_i = analog_o.converter_enable ? data_val : ~data_val;
endmodule

/* File: testbench.sv */
`timescale 1ns/1ps
`include "acc_consts.svh"
module testbench;
    logic                 mclk_i, rstn_i, abort_req, trig_req, conv_done_pulse_o, amp_out_change_i;
    logic [11:0]          s_axi_awaddr, s_axi_araddr;
    logic [31:0]          s_axi_wdata, s_axi_rdata;
    logic [3:0]           s_axi_wstrb;
    logic [1:0]           s_axi_bresp, s_axi_rresp;
    logic                 s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic                 s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [13:0]          trig_flags_i;
    logic [2:0]           pwm_sync_i;
    logic [9:0]           conv_data_i, data_val;
    acc_pkg::acc_analog_t analog_o;
    int                   err_total = 0, checked = 0, cycles = 0;
    logic [7:0]           v;
    logic [1:0]           r;
    acc_top i_dut (.mclk_i(mclk_i), .rstn_i(rstn_i), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .trig_flags_i(trig_flags_i), .pwm_sync_i(pwm_sync_i), .amp_out_change_i(amp_out_change_i),
        .conv_data_i(conv_data_i), .analog_o(analog_o), .conv_done_pulse_o(conv_done_pulse_o));
    acc_far_model i_far (.mclk_i(mclk_i), .rstn_i(rstn_i), .analog_o(analog_o), .data_val(data_val),
        .abort_req(abort_req), .trig_req(trig_req), .conv_data_i(conv_data_i),
        .amp_out_change_i(amp_out_change_i), .pwm_sync_i(pwm_sync_i), .trig_flags_i(trig_flags_i));
    initial begin
        mclk_i = 1'h0;
        forever #10 mclk_i = ~mclk_i;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask
    task automatic summarize;
        $display("mismatches %0d, comparisons %0d", err_total, checked);
        if (err_total == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    always @(posedge mclk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_total++;
            summarize();
        end
    end
    // Ready is looked at mid-cycle; the transfer itself happens at the following rising edge.
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic ha, hw, aw, w, b;
        aw = 1'h0;
        w = 1'h0;
        b = 1'h0;
        @(posedge mclk_i);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        while (!(aw && w)) begin
            @(negedge mclk_i);
            ha = s_axi_awvalid && s_axi_awready;
            hw = s_axi_wvalid && s_axi_wready;
            @(posedge mclk_i);
            if (ha) s_axi_awvalid <= 1'h0;
            if (hw) s_axi_wvalid <= 1'h0;
            aw = aw || ha;
            w = w || hw;
        end
        while (!b) begin
            @(negedge mclk_i);
            b = s_axi_bvalid;
            @(posedge mclk_i);
        end
        s_axi_bready <= 1'h0;
    endtask
    task automatic rd(input logic [11:0] a, output logic [7:0] d, output logic [1:0] rs);
        logic h;
        h = 1'h0;
        @(posedge mclk_i);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        while (!h) begin
            @(negedge mclk_i);
            h = s_axi_arvalid && s_axi_arready;
            @(posedge mclk_i);
        end
        s_axi_arvalid <= 1'h0;
        h = 1'h0;
        while (!h) begin
            @(negedge mclk_i);
            h = s_axi_rvalid;
            d = s_axi_rdata[7:0];
            rs = s_axi_rresp;
            @(posedge mclk_i);
        end
        s_axi_rready <= 1'h0;
    endtask
    task automatic rdc(input logic [11:0] a, input logic [7:0] exp, input string msg);
        rd(a, v, r);
        chk(v, exp, msg);
    endtask
    task automatic wait_done;
        v = 8'h00;
        for (int n = 0; n < 300 && !v[4]; n++) rd(`ACC_OFF_CTLA, v, r);
        chk(v & 8'h10, 8'h10, "done flag");
    endtask
    task automatic t_reset;
        for (int i = 0; i < 8; i++) rdc(12'(i * 4), 8'h00, "reset value");
        rd(12'h020, v, r);
        chk({6'h00, r}, 8'h02, "unmapped resp");
        chk(v, 8'h00, "unmapped data");
    endtask
    task automatic t_single;
        data_val <= 10'h271;
        wr(`ACC_OFF_MUX, 8'h43);
        wr(`ACC_OFF_CTLA, 8'hC0);
        wait_done();
        rdc(`ACC_OFF_CTLA, 8'h90, "start cleared");
        rdc(`ACC_OFF_RESL, 8'h71, "low right");
        rdc(`ACC_OFF_RESH, 8'h02, "high right");
        wr(`ACC_OFF_MUX, 8'h63);
        rdc(`ACC_OFF_RESL, 8'h40, "low left");
        rdc(`ACC_OFF_RESH, 8'h9C, "high left");
        chk({6'h00, analog_o.reference_select}, 8'h01, "reference");
        chk({3'h0, analog_o.channel_select}, 8'h03, "channel");
    endtask
    task automatic t_defer;
        wr(`ACC_OFF_CTLA, 8'hD0);
        wr(`ACC_OFF_MUX, 8'hC5);
        wr(`ACC_OFF_CTLA, 8'h00);
        rdc(`ACC_OFF_CTLA, 8'h40, "start kept");
        chk({3'h0, analog_o.channel_select}, 8'h03, "channel held");
        chk({6'h00, analog_o.reference_select}, 8'h01, "reference held");
        wait_done();
        chk({3'h0, analog_o.channel_select}, 8'h05, "channel taken");
        chk({6'h00, analog_o.reference_select}, 8'h03, "reference taken");
        chk({7'h00, analog_o.converter_enable}, 8'h00, "disabled after");
    endtask
    task automatic t_lock;
        rdc(`ACC_OFF_RESL, 8'h71, "low read");
        data_val <= 10'h3FF;
        wr(`ACC_OFF_CTLA, 8'hD0);
        wait_done();
        rdc(`ACC_OFF_RESH, 8'h02, "locked high");
        wr(`ACC_OFF_CTLA, 8'hD0);
        wait_done();
        rdc(`ACC_OFF_RESL, 8'hFF, "new low");
        rdc(`ACC_OFF_RESH, 8'h03, "new high");
    endtask
    task automatic t_amp;
        wr(`ACC_OFF_AMP0, 8'h20);
        wr(`ACC_OFF_AMP0, 8'hA0);
        wr(`ACC_OFF_MUX, 8'h4E);
        abort_req <= 1'h1;
        wr(`ACC_OFF_CTLA, 8'hD3);
        chk({6'h00, analog_o.amp_gain}, 8'h02, "gain");
        rdc(`ACC_OFF_CTLA, 8'hC3, "start during abort");
        wait_done();
        abort_req <= 1'h0;
        rdc(`ACC_OFF_CTLA, 8'h93, "start after restart");
    endtask
    task automatic t_auto;
        wr(`ACC_OFF_MUX, 8'h43);
        wr(`ACC_OFF_CTLB, 8'h01);
        wr(`ACC_OFF_CTLA, 8'hB0);
        trig_req <= 1'h1;
        wait_done();
        trig_req <= 1'h0;
        rdc(`ACC_OFF_CTLA, 8'hB0, "auto mode");
        wr(`ACC_OFF_AMP0, 8'hA1);
        wr(`ACC_OFF_MUX, 8'h4E);
        wr(`ACC_OFF_CTLA, 8'hB0);
        trig_req <= 1'h1;
        wait_done();
        wr(`ACC_OFF_CTLB, 8'h00);
        wr(`ACC_OFF_MUX, 8'h43);
        wr(`ACC_OFF_CTLA, 8'hF0);
        wait_done();
        wr(`ACC_OFF_CTLA, 8'hB0);
        wait_done();
        rdc(`ACC_OFF_CTLA, 8'hB0, "free run");
    endtask
    initial begin
        rstn_i = 1'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hF;
        data_val = 10'h000;
        abort_req = 1'h0;
        trig_req = 1'h0;
        repeat (12) @(posedge mclk_i);
        rstn_i <= 1'h1;
        t_reset();
        t_single();
        t_defer();
        t_lock();
        t_amp();
        t_auto();
        summarize();
    end
endmodule
